/* File: rtl/nvc_nested_vectored_irq_unit.sv */
// Nested vectored interrupt controller with tick timer and register port.
//
// The implementer's own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
// What this block does
// - Accepts 52 external interrupt lines, each with one of eight priority levels.
// - Each external line is configured as level or edge sensitive.
// - Arbitrates pending interrupts by priority and presents the winner to the core.
// - Priorities are software writable; a mask level suppresses equal or lower priorities.
// - System exceptions and peripheral interrupts share one priority scheme.
// - Each peripheral drives one combined interrupt line into the controller.
// - Vector addresses come from a relocatable software programmed vector base.
// - A higher interrupt arriving during state save, before the commit cycle, is serviced first, without new entry.
// - Core state is saved on entry and restored on return by hardware.
// - While asleep a separate wake unit prioritizes interrupts and wakes the core.
// - Supports wait-for-interrupt, wait-for-event and signal-event sleep controls.
// - With sleep-on-return set, returning to thread mode enters sleep.
// - Tick timer raises its own exception; counts system clock or tick clock.
// - A memory protection violation raises a memory management fault exception.
module nvc_nested_vectored_irq_unit
  import nvc_pkg::*;
(
  input  wire logic                   i_clk,
  input  wire logic                   i_rst_n,
  input  wire logic [7:0]             i_addr,
  input  wire logic [31:0]            i_wdata,
  input  wire logic                   i_wr,
  input  wire logic                   i_rd,
  output logic      [31:0]            o_rdata,
  input  wire logic [nvc_pkg::NVC_NUM_EXT-1:0] i_irq_lines,
  input  wire logic                   i_mem_fault,
  input  wire logic                   i_tick_clk,
  input  wire logic                   i_exc_ack,
  input  wire logic                   i_exc_return,
  input  wire logic                   i_wait_irq_sleep,
  input  wire logic                   i_wait_event_sleep,
  input  wire logic                   i_signal_event,
  output logic                        o_exc_req,
  output logic      [7:0]             o_exc_num,
  output logic      [31:0]            o_vector_addr,
  output logic                        o_state_save,
  output logic                        o_entry_done,
  output logic                        o_state_restore,
  output logic                        o_core_sleep,
  output logic                        o_irq
);
  import nvc_pkg::*;
  localparam int N = NVC_NUM_EXT;

  nvc_wake_if wk ();

  logic [N-1:0]          sync1_q, sync2_q, prev_q, edge_pend_q, en_q, edge_q;
  logic [NVC_PRIO_W-1:0] prio_q [N];
  logic [NVC_PRIO_W-1:0] mask_q, tprio_q;
  logic [2:0]            ctrl_q;
  logic [31:0]           vbase_q;
  logic [23:0]           reload_q, tcnt_q;
  logic [NVC_ST_W-1:0]   status_q, imask_q;
  logic                  fault_pend_q, tick_pend_q;
  logic                  t1_q, t2_q, t3_q;
  logic [8:0]            active_q;
  nvc_entry_e            ent_q;
  logic [3:0]            cnt_q;
  logic [5:0]            cur_src_q;
  logic [3:0]            cur_ip_q;
  logic                  asleep_q, wfe_q, event_q;
  logic                  exc_req_q, save_q, done_q, restore_q, irq_q;
  logic [7:0]            num_q;
  logic [31:0]           vaddr_q, rdata_q;

  // Line inputs come from other clock domains and are synchronized first.
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
      prev_q  <= '0;
      t1_q    <= 1'b0;
      t2_q    <= 1'b0;
      t3_q    <= 1'b0;
    end
    else
    begin
      sync1_q <= i_irq_lines;
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
      t1_q    <= i_tick_clk;
      t2_q    <= t1_q;
      t3_q    <= t2_q;
    end
  end

  wire       wr_hit_sw = i_wr && (i_addr == NVC_A_SWPEND);
  wire       commit    = (ent_q == NVC_ENT_SAVE) && (cnt_q == 4'h0);
  wire [N-1:0] rise    = sync2_q & ~prev_q;
  wire [N-1:0] sw_set  = wr_hit_sw ? (N'(1) << i_wdata[5:0]) : '0;
  wire [N-1:0] take    = (commit && cur_src_q < 6'(N)) ? (N'(1) << cur_src_q) : '0;
  wire [N-1:0] pend_ext = (edge_q & edge_pend_q) | (~edge_q & sync2_q);

  // Pending source flags: a set in the same cycle as a take wins.
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      edge_pend_q <= '0;
    else
      edge_pend_q <= ((rise & edge_q) | sw_set) | (edge_pend_q & ~take);
  end

  // Tick timer with selectable count clock.
  wire tick_step = ctrl_q[NVC_C_TSEL] ? (t2_q & ~t3_q) : 1'b1;
  wire tick_wrap = ctrl_q[NVC_C_TEN] && tick_step && (tcnt_q == 24'h0);
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      tcnt_q <= NVC_RELOAD_RST;
    else if (ctrl_q[NVC_C_TEN] && tick_step)
      tcnt_q <= (tcnt_q == 24'h0) ? reload_q : tcnt_q - 24'h1;
  end

  wire take_fault = commit && (cur_src_q == 6'(NVC_SRC_FAULT));
  wire take_tick  = commit && (cur_src_q == 6'(NVC_SRC_TICK));
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      fault_pend_q <= 1'b0;
      tick_pend_q  <= 1'b0;
    end
    else
    begin
      fault_pend_q <= i_mem_fault | (fault_pend_q & ~take_fault);
      tick_pend_q  <= tick_wrap | (tick_pend_q & ~take_tick);
    end
  end

  // Eligibility and internal priority of all sources; fault outranks all levels.
  logic [NVC_NUM_SRC-1:0] elig;
  logic [3:0]             ip [NVC_NUM_SRC];
  logic [3:0]             best_ip, run_ip;
  logic [5:0]             best_src;
  always_comb
  begin
    for (int i = 0; i < N; i++)
    begin
      ip[i]   = 4'({1'b0, prio_q[i]}) + 4'h1;
      elig[i] = pend_ext[i] && en_q[i] && !(mask_q != 3'h0 && prio_q[i] >= mask_q);
    end
    ip[NVC_SRC_FAULT]   = NVC_IP_FAULT;
    elig[NVC_SRC_FAULT] = fault_pend_q;
    ip[NVC_SRC_TICK]    = 4'({1'b0, tprio_q}) + 4'h1;
    elig[NVC_SRC_TICK]  = tick_pend_q && !(mask_q != 3'h0 && tprio_q >= mask_q);
    best_ip  = NVC_IP_IDLE;
    best_src = 6'h0;
    for (int i = 0; i < NVC_NUM_SRC; i++)
    begin
      if (elig[i] && ip[i] < best_ip)
      begin
        best_ip  = ip[i];
        best_src = 6'(i);
      end
    end
    run_ip = NVC_IP_IDLE;
    for (int l = 8; l >= 0; l--)
    begin
      if (active_q[l])
        run_ip = 4'(l);
    end
  end

  wire preempt = best_ip < run_ip;
  // An arrival in the commit cycle is left for the next entry, so the number stays true.
  wire late    = (ent_q == NVC_ENT_SAVE) && !commit && (best_ip < cur_ip_q);
  wire ret_ok  = i_exc_return && (ent_q == NVC_ENT_IDLE) && (active_q != 9'h0);
  wire [8:0] popped = active_q & (active_q - 9'h1);
  wire sor_sleep = ret_ok && (popped == 9'h0) && ctrl_q[NVC_C_SOR];

  // Exception entry: state save runs a fixed count; late arrivals retarget it.
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      ent_q     <= NVC_ENT_IDLE;
      cnt_q     <= 4'h0;
      cur_src_q <= 6'h0;
      cur_ip_q  <= NVC_IP_IDLE;
      active_q  <= 9'h0;
    end
    else
    begin
      unique case (ent_q)
        NVC_ENT_IDLE:
        begin
          if (i_exc_ack && exc_req_q && preempt)
          begin
            ent_q     <= NVC_ENT_SAVE;
            cnt_q     <= 4'(NVC_STACK_CYC - 1);
            cur_src_q <= best_src;
            cur_ip_q  <= best_ip;
          end
          if (ret_ok)
            active_q <= popped;
        end
        NVC_ENT_SAVE:
        begin
          if (late)
          begin
            cur_src_q <= best_src;
            cur_ip_q  <= best_ip;
          end
          if (commit)
          begin
            ent_q    <= NVC_ENT_IDLE;
            active_q <= active_q | (9'h1 << cur_ip_q);
          end
          else
            cnt_q <= cnt_q - 4'h1;
        end
      endcase
    end
  end

  wire [5:0] out_src = (ent_q == NVC_ENT_IDLE) ? best_src : (late ? best_src : cur_src_q);
  wire [7:0] num_d   = (out_src == 6'(NVC_SRC_FAULT)) ? NVC_EXC_FAULT :
                       (out_src == 6'(NVC_SRC_TICK))  ? NVC_EXC_TICK  :
                       NVC_EXC_EXT + 8'(out_src);
  wire [31:0] vaddr_d = vbase_q + {22'h0, num_d, 2'b00};

  // Sleep control: the event latch lets a signal-event cancel or end a wait.
  wire wake_evt = asleep_q && (wk.wake || (wfe_q && event_q));
  wire go_sleep = i_wait_irq_sleep || (i_wait_event_sleep && !event_q) || sor_sleep;
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      asleep_q <= 1'b0;
      wfe_q    <= 1'b0;
      event_q  <= 1'b0;
    end
    else
    begin
      if (wake_evt)
        asleep_q <= 1'b0;
      else if (go_sleep)
        asleep_q <= 1'b1;
      if (go_sleep && !asleep_q)
        wfe_q <= i_wait_event_sleep && !i_wait_irq_sleep;
      event_q <= i_signal_event ||
                 (event_q && !i_wait_event_sleep && !(wake_evt && wfe_q));
    end
  end

  assign wk.eligible = elig;
  assign wk.run_ip   = run_ip;
  assign wk.asleep   = asleep_q;
  for (genvar g = 0; g < NVC_NUM_SRC; g++)
  begin : g_ip
    assign wk.ip_flat[g*NVC_IP_W +: NVC_IP_W] = ip[g];
  end

  nvc_sleep_wake_irq_unit u_wake (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .wk      (wk)
  );

  // Register port writes.
  wire [2:0] pword = i_addr[4:2];
  wire       pwr   = i_wr && i_addr >= NVC_A_PRIO0 && pword < 3'(NVC_PRIO_WORDS)
                     && i_addr[7:5] == 3'h2;
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      ctrl_q   <= NVC_CTRL_RST;
      mask_q   <= '0;
      tprio_q  <= '0;
      vbase_q  <= NVC_VBASE_RST;
      reload_q <= NVC_RELOAD_RST;
      imask_q  <= '0;
      en_q     <= '0;
      edge_q   <= '0;
      for (int i = 0; i < N; i++)
        prio_q[i] <= '0;
    end
    else
    begin
      if (i_wr)
      begin
        unique case (i_addr)
          NVC_A_CTRL:   ctrl_q   <= i_wdata[2:0];
          NVC_A_MASK:   mask_q   <= i_wdata[2:0];
          NVC_A_VBASE:  vbase_q  <= {i_wdata[31:NVC_VBASE_LSB], 9'h0};
          NVC_A_RELOAD: reload_q <= i_wdata[23:0];
          NVC_A_TPRIO:  tprio_q  <= i_wdata[2:0];
          NVC_A_IMASK:  imask_q  <= i_wdata[NVC_ST_W-1:0];
          NVC_A_EN0:    en_q[31:0] <= i_wdata;
          NVC_A_EN1:    en_q[N-1:32] <= i_wdata[N-33:0];
          NVC_A_EDGE0:  edge_q[31:0] <= i_wdata;
          NVC_A_EDGE1:  edge_q[N-1:32] <= i_wdata[N-33:0];
          default:      ;
        endcase
      end
      if (pwr)
      begin
        for (int k = 0; k < 8; k++)
        begin
          if (int'(pword) * 8 + k < N)
            prio_q[int'(pword) * 8 + k] <= i_wdata[4*k +: NVC_PRIO_W];
        end
      end
    end
  end

  // Status flags clear on read; a new event in the reading cycle still sets.
  wire                rd_status = i_rd && (i_addr == NVC_A_STATUS);
  wire [NVC_ST_W-1:0] st_set    = {wk.wake & asleep_q, late, tick_wrap, i_mem_fault};
  wire [NVC_ST_W-1:0] status_d  = st_set | (rd_status ? '0 : status_q);

  logic [31:0] rmux;
  always_comb
  begin
    rmux = 32'h0;
    unique case (i_addr)
      NVC_A_CTRL:   rmux = {29'h0, ctrl_q};
      NVC_A_MASK:   rmux = {29'h0, mask_q};
      NVC_A_VBASE:  rmux = vbase_q;
      NVC_A_RELOAD: rmux = {8'h0, reload_q};
      NVC_A_TVALUE: rmux = {8'h0, tcnt_q};
      NVC_A_TPRIO:  rmux = {29'h0, tprio_q};
      NVC_A_STATUS: rmux = {28'h0, status_q};
      NVC_A_IMASK:  rmux = {28'h0, imask_q};
      NVC_A_EN0:    rmux = en_q[31:0];
      NVC_A_EN1:    rmux = {12'h0, en_q[N-1:32]};
      NVC_A_EDGE0:  rmux = edge_q[31:0];
      NVC_A_EDGE1:  rmux = {12'h0, edge_q[N-1:32]};
      NVC_A_PEND0:  rmux = pend_ext[31:0];
      NVC_A_PEND1:  rmux = {12'h0, pend_ext[N-1:32]};
      NVC_A_STATE:  rmux = {asleep_q, 7'h0, num_q, 6'h0, ent_q, 8'h0};
      default:
      begin
        if (i_addr >= NVC_A_PRIO0 && i_addr[7:5] == 3'h2 && pword < 3'(NVC_PRIO_WORDS))
        begin
          for (int k = 0; k < 8; k++)
          begin
            if (int'(pword) * 8 + k < N)
              rmux[4*k +: NVC_PRIO_W] = prio_q[int'(pword) * 8 + k];
          end
        end
      end
    endcase
  end

  // Every output is registered.
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      status_q  <= '0;
      rdata_q   <= 32'h0;
      exc_req_q <= 1'b0;
      num_q     <= 8'h0;
      vaddr_q   <= 32'h0;
      save_q    <= 1'b0;
      done_q    <= 1'b0;
      restore_q <= 1'b0;
      irq_q     <= 1'b0;
    end
    else
    begin
      status_q  <= status_d;
      rdata_q   <= i_rd ? rmux : 32'h0;
      exc_req_q <= (ent_q == NVC_ENT_IDLE) && preempt && !asleep_q && !i_exc_ack;
      num_q     <= num_d;
      vaddr_q   <= vaddr_d;
      save_q    <= (ent_q == NVC_ENT_SAVE) && !commit;
      done_q    <= commit;
      restore_q <= ret_ok;
      irq_q     <= |(status_d & imask_q);
    end
  end

  assign o_rdata         = rdata_q;
  assign o_exc_req       = exc_req_q;
  assign o_exc_num       = num_q;
  assign o_vector_addr   = vaddr_q;
  assign o_state_save    = save_q;
  assign o_entry_done    = done_q;
  assign o_state_restore = restore_q;
  assign o_core_sleep    = asleep_q;
  assign o_irq           = irq_q;
endmodule

/* File: rtl/nvc_pkg.sv */
// Constants, register map and types shared by the interrupt controller files.
package nvc_pkg;
  localparam int          NVC_NUM_EXT   = 52;
  localparam int          NVC_NUM_SRC   = 54;
  localparam int          NVC_PRIO_W    = 3;
  localparam int          NVC_IP_W      = 4;
  localparam int          NVC_SRC_FAULT = 52;
  localparam int          NVC_SRC_TICK  = 53;
  localparam int          NVC_STACK_CYC = 8;
  localparam logic [3:0]  NVC_IP_FAULT  = 4'h0;
  localparam logic [3:0]  NVC_IP_IDLE   = 4'hf;
  localparam logic [7:0]  NVC_EXC_FAULT = 8'h04;
  localparam logic [7:0]  NVC_EXC_TICK  = 8'h0f;
  localparam logic [7:0]  NVC_EXC_EXT   = 8'h10;
  localparam logic [7:0]  NVC_A_CTRL    = 8'h00;
  localparam logic [7:0]  NVC_A_MASK    = 8'h04;
  localparam logic [7:0]  NVC_A_VBASE   = 8'h08;
  localparam logic [7:0]  NVC_A_RELOAD  = 8'h0c;
  localparam logic [7:0]  NVC_A_TVALUE  = 8'h10;
  localparam logic [7:0]  NVC_A_TPRIO   = 8'h14;
  localparam logic [7:0]  NVC_A_STATUS  = 8'h18;
  localparam logic [7:0]  NVC_A_IMASK   = 8'h1c;
  localparam logic [7:0]  NVC_A_EN0     = 8'h20;
  localparam logic [7:0]  NVC_A_EN1     = 8'h24;
  localparam logic [7:0]  NVC_A_EDGE0   = 8'h28;
  localparam logic [7:0]  NVC_A_EDGE1   = 8'h2c;
  localparam logic [7:0]  NVC_A_PEND0   = 8'h30;
  localparam logic [7:0]  NVC_A_PEND1   = 8'h34;
  localparam logic [7:0]  NVC_A_SWPEND  = 8'h38;
  localparam logic [7:0]  NVC_A_STATE   = 8'h3c;
  localparam logic [7:0]  NVC_A_PRIO0   = 8'h40;
  localparam int          NVC_PRIO_WORDS = 7;
  localparam int          NVC_C_SOR     = 0;
  localparam int          NVC_C_TEN     = 1;
  localparam int          NVC_C_TSEL    = 2;
  localparam int          NVC_VBASE_LSB = 9;
  localparam int          NVC_ST_FAULT  = 0;
  localparam int          NVC_ST_TICK   = 1;
  localparam int          NVC_ST_LATE   = 2;
  localparam int          NVC_ST_WAKE   = 3;
  localparam int          NVC_ST_W      = 4;
  localparam logic [31:0] NVC_VBASE_RST = 32'h0000_0000;
  localparam logic [23:0] NVC_RELOAD_RST = 24'h00_0000;
  localparam logic [2:0]  NVC_CTRL_RST  = 3'h0;
  typedef enum logic [1:0] {
    NVC_ENT_IDLE = 2'b01,
    NVC_ENT_SAVE = 2'b10
  } nvc_entry_e;
endpackage

/* File: rtl/nvc_sleep_wake_irq_unit.sv */
// Sleep wake unit: prioritizes pending interrupts while the controller sleeps.
`timescale 1ns/1ps
module nvc_sleep_wake_irq_unit
  import nvc_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  nvc_wake_if.unit  wk
);
  logic [NVC_IP_W-1:0] best_ip;
  logic                wake_q;
  logic [NVC_IP_W-1:0] wake_ip_q;

  always_comb
  begin
    best_ip = NVC_IP_IDLE;
    for (int i = 0; i < NVC_NUM_SRC; i++)
    begin
      if (wk.eligible[i] && (wk.ip_flat[i*NVC_IP_W +: NVC_IP_W] < best_ip))
        best_ip = wk.ip_flat[i*NVC_IP_W +: NVC_IP_W];
    end
  end

  // Only an interrupt that would preempt the running level wakes the core.
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      wake_q    <= 1'b0;
      wake_ip_q <= NVC_IP_IDLE;
    end
    else
    begin
      wake_q    <= wk.asleep && (best_ip < wk.run_ip);
      wake_ip_q <= best_ip;
    end
  end

  assign wk.wake    = wake_q;
  assign wk.wake_ip = wake_ip_q;
endmodule

/* File: rtl/nvc_wake_if.sv */
// Signals between the main controller and the sleep wake unit.
`timescale 1ns/1ps
interface nvc_wake_if;
  import nvc_pkg::*;
  logic [NVC_NUM_SRC-1:0]          eligible;
  logic [NVC_NUM_SRC*NVC_IP_W-1:0] ip_flat;
  logic [NVC_IP_W-1:0]             run_ip;
  logic                            asleep;
  logic                            wake;
  logic [NVC_IP_W-1:0]             wake_ip;
  modport ctrl (output eligible, ip_flat, run_ip, asleep, input wake, wake_ip);
  modport unit (input eligible, ip_flat, run_ip, asleep, output wake, wake_ip);
endinterface

/* File: sim/nvc_core_model.sv */
// Core-side partner: accepts offered exceptions and returns from handlers.
`timescale 1ns/1ps
module nvc_core_model (
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_exc_req,
  input  wire logic       i_entry_done,
  input  wire logic       i_ret_req,
  input  wire logic [3:0] i_ack_wait,
  output logic            o_exc_ack,
  output logic            o_exc_return
);
  logic [3:0] wait_q;
  logic [3:0] depth_q;
  logic       ret_ok;
  // A return is only issued while a finished entry is outstanding.
  assign ret_ok = i_ret_req && (depth_q != 4'h0 || i_entry_done);
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      wait_q       <= 4'h0;
      depth_q      <= 4'h0;
      o_exc_ack    <= 1'b0;
      o_exc_return <= 1'b0;
    end
    else
    begin
      o_exc_ack    <= i_exc_req && !o_exc_ack && wait_q == i_ack_wait;
      wait_q       <= (i_exc_req && wait_q != i_ack_wait) ? wait_q + 4'h1 : 4'h0;
      o_exc_return <= ret_ok;
      depth_q      <= depth_q + {3'h0, i_entry_done} - {3'h0, ret_ok};
    end
  end
endmodule

/* File: sim/nvc_irq_chk.sv */
// Concurrent checks on the interrupt controller top ports.
`timescale 1ns/1ps
module nvc_irq_chk
  import nvc_pkg::*;
(
  input wire logic        i_clk,
  input wire logic        i_rst_n,
  input wire logic [7:0]  i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [31:0] o_rdata,
  input wire logic        i_exc_ack,
  input wire logic        i_exc_return,
  input wire logic        i_wait_irq_sleep,
  input wire logic        o_exc_req,
  input wire logic [7:0]  o_exc_num,
  input wire logic [31:0] o_vector_addr,
  input wire logic        o_state_save,
  input wire logic        o_entry_done,
  input wire logic        o_state_restore,
  input wire logic        o_core_sleep
);
  logic [31:0] vbase_q;
  // Shadow of the vector base so vector addresses can be predicted.
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      vbase_q <= 32'h0;
    else if (i_wr && i_addr == NVC_A_VBASE)
      vbase_q <= {i_wdata[31:9], 9'h000};
  end
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);
  property p_ack_req;
    o_exc_req && i_exc_ack |=> !o_exc_req;
  endproperty
  property p_save;
    o_exc_req && i_exc_ack |=> !o_state_save ##1 o_state_save [*7] ##1
      (!o_state_save && o_entry_done);
  endproperty
  property p_done_pulse;
    o_entry_done |=> !o_entry_done;
  endproperty
  property p_vector;
    o_entry_done |-> o_vector_addr == vbase_q + {22'h0, o_exc_num, 2'b00};
  endproperty
  property p_exc_num;
    o_entry_done |-> o_exc_num == NVC_EXC_FAULT || o_exc_num == NVC_EXC_TICK ||
      (o_exc_num >= NVC_EXC_EXT && o_exc_num <= 8'h43);
  endproperty
  property p_restore;
    o_state_restore |-> $past(i_exc_return);
  endproperty
  property p_rdata_idle;
    !$past(i_rd) |-> o_rdata == 32'h0;
  endproperty
  property p_sleep_enter;
    i_wait_irq_sleep && !o_exc_req |=> o_core_sleep;
  endproperty
  property p_sleep_quiet;
    o_core_sleep && $past(o_core_sleep) |-> !o_exc_req;
  endproperty
  a_ack_req: assert property (p_ack_req) else $error("request held after ack");
  a_save: assert property (p_save) else $error("state save timing wrong");
  a_done_pulse: assert property (p_done_pulse) else $error("entry done too long");
  a_vector: assert property (p_vector) else $error("vector address wrong");
  a_exc_num: assert property (p_exc_num) else $error("exception number out of range");
  a_restore: assert property (p_restore) else $error("restore without return");
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
  a_sleep_enter: assert property (p_sleep_enter) else $error("sleep not entered");
  a_sleep_quiet: assert property (p_sleep_quiet) else $error("request while asleep");
  c_entry: cover property (o_entry_done);
  c_restore: cover property (o_state_restore);
  c_wake: cover property (o_core_sleep ##1 !o_core_sleep);
endmodule

bind nvc_nested_vectored_irq_unit nvc_irq_chk u_chk (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_exc_ack(i_exc_ack),
  .i_exc_return(i_exc_return), .i_wait_irq_sleep(i_wait_irq_sleep),
  .o_exc_req(o_exc_req), .o_exc_num(o_exc_num), .o_vector_addr(o_vector_addr),
  .o_state_save(o_state_save), .o_entry_done(o_entry_done),
  .o_state_restore(o_state_restore), .o_core_sleep(o_core_sleep)
);

/* File: sim/nvc_nested_vectored_irq_unit_tb.sv */
// Self-checking testbench for the nested vectored interrupt controller.
`timescale 1ns/1ps
module nvc_nested_vectored_irq_unit_tb;
  import nvc_pkg::*;
  logic                   i_clk, i_rst_n, i_wr, i_rd, i_mem_fault, i_tick_clk;
  logic                   i_exc_ack, i_exc_return, i_wait_irq_sleep;
  logic                   i_wait_event_sleep, i_signal_event, ret_req;
  logic                   o_exc_req, o_state_save, o_entry_done;
  logic                   o_state_restore, o_core_sleep, o_irq;
  logic [7:0]             i_addr, o_exc_num;
  logic [31:0]            i_wdata, o_rdata, o_vector_addr, vb;
  logic [NVC_NUM_EXT-1:0] i_irq_lines;
  logic [3:0]             ack_wait;
  int                     errors, total_checks, k;

  nvc_nested_vectored_irq_unit dut (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_irq_lines(i_irq_lines),
    .i_mem_fault(i_mem_fault), .i_tick_clk(i_tick_clk), .i_exc_ack(i_exc_ack),
    .i_exc_return(i_exc_return), .i_wait_irq_sleep(i_wait_irq_sleep),
    .i_wait_event_sleep(i_wait_event_sleep), .i_signal_event(i_signal_event),
    .o_exc_req(o_exc_req), .o_exc_num(o_exc_num), .o_vector_addr(o_vector_addr),
    .o_state_save(o_state_save), .o_entry_done(o_entry_done),
    .o_state_restore(o_state_restore), .o_core_sleep(o_core_sleep), .o_irq(o_irq)
  );
  nvc_core_model u_core (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_exc_req(o_exc_req),
    .i_entry_done(o_entry_done), .i_ret_req(ret_req), .i_ack_wait(ack_wait),
    .o_exc_ack(i_exc_ack), .o_exc_return(i_exc_return)
  );

  initial
  begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end
  always @(posedge i_clk) i_tick_clk <= ~i_tick_clk;

  task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("Error %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
    @(posedge i_clk);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e, input string n);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    chk(n, o_rdata, e);
    @(posedge i_clk);
  endtask
  task automatic ln(input logic [NVC_NUM_EXT-1:0] m);
    i_irq_lines <= m;
    @(posedge i_clk);
  endtask
  task automatic take(input logic [7:0] n);
    k = 0;
    while (o_entry_done !== 1'b1 && k < 200)
    begin
      @(posedge i_clk);
      #1;
      k++;
    end
    chk("exc_num", {24'h0, o_exc_num}, {24'h0, n});
    chk("vector", o_vector_addr, vb + {22'h0, n, 2'b00});
    chk("entry_done", {31'h0, o_entry_done}, 32'h1);
  endtask
  task automatic ret();
    k = 0;
    ret_req <= 1'b1;
    @(posedge i_clk);
    ret_req <= 1'b0;
    while (o_state_restore !== 1'b1 && k < 8)
    begin
      @(posedge i_clk);
      #1;
      k++;
    end
    chk("restore", {31'h0, o_state_restore}, 32'h1);
    @(posedge i_clk);
  endtask
  task automatic finish_test();
    $display("Checks %0d, errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge i_clk);
    $display("Error watchdog expired");
    errors++;
    finish_test();
  end

  initial
  begin
    {i_rst_n, i_wr, i_rd, i_mem_fault, i_tick_clk, ret_req} = 6'h0;
    {i_wait_irq_sleep, i_wait_event_sleep, i_signal_event} = 3'h0;
    i_addr = 8'h0;
    i_wdata = 32'h0;
    i_irq_lines = '0;
    ack_wait = 4'h3;
    errors = 0;
    total_checks = 0;
    repeat (4) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(posedge i_clk);
    rc(NVC_A_CTRL, 32'h0, "ctrl");
    rc(NVC_A_PRIO0, 32'h0, "prio0");
    rc(8'h80, 32'h0, "unmapped");
    wr(NVC_A_VBASE, 32'h0000_0bff);
    vb = 32'h0000_0a00;
    rc(NVC_A_VBASE, vb, "vbase");
    wr(NVC_A_PRIO0, 32'h0600_2415);
    wr(NVC_A_EDGE0, 32'h48);
    wr(NVC_A_EN0, 32'h2cf);
    rc(NVC_A_PRIO0, 32'h0600_2415, "prio0");
    rc(NVC_A_EDGE0, 32'h48, "edge0");
    // Short edge pulse with a slow core acknowledge.
    ln(52'h8);
    ln(52'h0);
    take(8'h13);
    ret();
    wr(NVC_A_SWPEND, 32'h3);
    take(8'h13);
    ret();
    // Priority choice, no preemption by lower level, nesting.
    ack_wait <= 4'h0;
    ln(52'h3);
    take(8'h11);
    ln(52'h1);
    repeat (12) @(posedge i_clk);
    #1;
    chk("no_preempt", {31'h0, o_exc_req}, 32'h0);
    ln(52'h81);
    take(8'h17);
    ln(52'h1);
    ret();
    ret();
    take(8'h10);
    ln(52'h0);
    ret();
    // Masking and level pending.
    wr(NVC_A_MASK, 32'h3);
    ln(52'h4);
    repeat (12) @(posedge i_clk);
    #1;
    chk("masked", {31'h0, o_exc_req}, 32'h0);
    rc(NVC_A_PEND0, 32'h4, "pend0");
    ln(52'h0);
    repeat (4) @(posedge i_clk);
    rc(NVC_A_PEND0, 32'h0, "pend0");
    ln(52'h4);
    wr(NVC_A_MASK, 32'h0);
    take(8'h12);
    ln(52'h0);
    ret();
    // Protection fault, status interrupt and clear on read.
    wr(NVC_A_IMASK, 32'h1);
    i_mem_fault <= 1'b1;
    @(posedge i_clk);
    i_mem_fault <= 1'b0;
    take(NVC_EXC_FAULT);
    chk("irq", {31'h0, o_irq}, 32'h1);
    rc(NVC_A_STATUS, 32'h1, "status");
    #1;
    chk("irq", {31'h0, o_irq}, 32'h0);
    ret();
    // Late arrival of a higher level during state save.
    ln(52'h40);
    ln(52'h0);
    k = 0;
    while (o_state_save !== 1'b1 && k < 40)
    begin
      @(posedge i_clk);
      #1;
      k++;
    end
    ln(52'h80);
    take(8'h17);
    ln(52'h0);
    rc(NVC_A_STATUS, 32'h4, "status");
    ret();
    take(8'h16);
    ret();
    // Tick timer on the system clock.
    wr(NVC_A_RELOAD, 32'h40);
    wr(NVC_A_CTRL, 32'h2);
    take(NVC_EXC_TICK);
    wr(NVC_A_CTRL, 32'h0);
    rc(NVC_A_STATUS, 32'h2, "status");
    ret();
    // Event latch, sleep, wake and sleep on return.
    i_signal_event <= 1'b1;
    @(posedge i_clk);
    i_signal_event <= 1'b0;
    i_wait_event_sleep <= 1'b1;
    @(posedge i_clk);
    i_wait_event_sleep <= 1'b0;
    #1;
    chk("event_sleep", {31'h0, o_core_sleep}, 32'h0);
    wr(NVC_A_CTRL, 32'h1);
    i_wait_irq_sleep <= 1'b1;
    @(posedge i_clk);
    i_wait_irq_sleep <= 1'b0;
    #1;
    chk("asleep", {31'h0, o_core_sleep}, 32'h1);
    ln(52'h200);
    take(8'h19);
    ln(52'h0);
    rc(NVC_A_STATUS, 32'h8, "status");
    ret();
    repeat (2) @(posedge i_clk);
    #1;
    chk("return_sleep", {31'h0, o_core_sleep}, 32'h1);
    finish_test();
  end
endmodule
